// *** mrr_pkg.sv ***
// constants and helpers for the monitor result registers
// assumes one 20 MHz clock domain and a register port behind the serial bus
package mrr_pkg;
    // --------------------------------------------------------------
    // register offsets
    // --------------------------------------------------------------
    localparam logic [7:0] MRR_OFS_BUS = 8'h05;
    localparam logic [7:0] MRR_OFS_POWER = 8'h06;
    localparam logic [7:0] MRR_OFS_CURRENT = 8'h07;
    localparam logic [7:0] MRR_OFS_LOCAL = 8'h08;
    localparam logic [7:0] MRR_OFS_REMOTE1 = 8'h09;
    localparam logic [7:0] MRR_OFS_REMOTE2 = 8'h0A;
    localparam logic [7:0] MRR_OFS_REMOTE3 = 8'h0B;
    localparam logic [7:0] MRR_OFS_SHUNT_UPPER = 8'h0C;
    // --------------------------------------------------------------
    // field layout and reset values
    // --------------------------------------------------------------
    localparam int MRR_CODE_LSB = 3;
    localparam int MRR_SUPPLY_BIT = 1;
    localparam int MRR_OPEN_BIT = 0;
    localparam logic [15:0] MRR_RESET_WORD = 16'h0000;
    localparam logic [12:0] MRR_BUS_FS_32V = 13'h1F40;
    localparam logic [12:0] MRR_BUS_FS_16V = 13'h0FA0;
    localparam logic [15:0] MRR_LIMIT_POS_FS = 16'h7D00;
    localparam logic [15:0] MRR_LIMIT_NEG_FS = 16'h8300;
    localparam logic [15:0] MRR_CAL_USED_MASK = 16'hFFFE;
    // --------------------------------------------------------------
    // arithmetic constants
    // --------------------------------------------------------------
    localparam int MRR_CURRENT_SHIFT = 12;
    localparam logic [31:0] MRR_POWER_DIVISOR = 32'h0000_1388;
    localparam logic [1:0] MRR_CH_LOCAL = 2'h0;
    localparam logic [1:0] MRR_CH_THIRD = 2'h3;

    typedef enum logic [1:0] {
        MRR_IDLE = 2'b00,
        MRR_POWER = 2'b01
    } mrr_arith_state_t;

    // clamp a signed value onto 16 signed bits
    function automatic logic [15:0] mrr_sat_s16(input logic signed [32:0] v);
        if (v > 33'sh0_0000_7FFF) begin
            return 16'h7FFF;
        end else if (v < -33'sh0_0000_8000) begin
            return 16'h8000;
        end
        return v[15:0];
    endfunction

    // clamp an unsigned value onto 16 bits
    function automatic logic [15:0] mrr_sat_u16(input logic [31:0] v);
        if (v > 32'h0000_FFFF) begin
            return 16'hFFFF;
        end
        return v[15:0];
    endfunction
endpackage

// *** mrr_arith.sv ***
// current and power computation from shunt reading and calibration
// assumes shunt_valid comes from converter logic on the same clock
`timescale 1ns/1ns
`default_nettype none
module mrr_arith (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // measurement inputs
    input wire logic shunt_valid,
    input wire logic [15:0] shunt_code,
    input wire logic [15:0] calibration,
    input wire logic [12:0] bus_code,
    // results
    output logic result_valid,
    output logic [15:0] current_word,
    output logic [15:0] power_word
);
    import mrr_pkg::*;

    typedef struct packed {
        mrr_arith_state_t st;
        logic valid;
        logic [15:0] cur;
        logic [15:0] pow;
    } mrr_arith_reg_t;

    mrr_arith_reg_t s_q, s_d;
    logic signed [32:0] prod_c;
    logic [15:0] mag_c;
    logic [31:0] prod_p;

    always_comb begin
        s_d = s_q;
        s_d.valid = 1'b0;
        // --------------------------------------------------------------
        // current = shunt * calibration / 4096, bit 0 of cal unused
        // --------------------------------------------------------------
        prod_c = $signed(shunt_code) * $signed({1'b0, calibration & MRR_CAL_USED_MASK});
        // --------------------------------------------------------------
        // power = |current| * bus / 5000
        // --------------------------------------------------------------
        mag_c = s_q.cur[15] ? 16'(-s_q.cur) : s_q.cur;
        prod_p = 32'(mag_c) * 32'(bus_code);
        unique case (s_q.st)
            MRR_IDLE: begin
                if (shunt_valid) begin
                    s_d.cur = mrr_sat_s16(prod_c >>> MRR_CURRENT_SHIFT);
                    s_d.st = MRR_POWER;
                end
            end
            MRR_POWER: begin
                s_d.pow = mrr_sat_u16(prod_p / MRR_POWER_DIVISOR);
                s_d.valid = 1'b1;
                s_d.st = MRR_IDLE;
            end
            default: begin
                s_d.st = MRR_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '{st: MRR_IDLE, valid: 1'b0, cur: MRR_RESET_WORD, pow: MRR_RESET_WORD};
        end else begin
            s_q <= s_d;
        end
    end

    assign result_valid = s_q.valid;
    assign current_word = s_q.cur;
    assign power_word = s_q.pow;
endmodule
`default_nettype wire

// *** mrr_temp.sv ***
// temperature conversion tracking and result word forming
// assumes supply and diode status arrive as asynchronous pins
`timescale 1ns/1ns
`default_nettype none
module mrr_temp #(
    parameter bit HAS_CH3 = 1'b1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // conversion control
    input wire logic conv_req,
    input wire logic [1:0] conv_chan,
    input wire logic conv_done,
    input wire logic [12:0] conv_code,
    output logic conv_go,
    // analog status pins
    input wire logic supply_ok_pin,
    input wire logic diode_open_pin,
    // result
    output logic commit,
    output logic [1:0] commit_chan,
    output logic [15:0] commit_word
);
    import mrr_pkg::*;

    typedef struct packed {
        logic sup_s1;
        logic sup_s2;
        logic dio_s1;
        logic dio_s2;
        logic active;
        logic [1:0] chan;
        logic drop;
        logic open;
        logic commit;
        logic [15:0] word;
    } mrr_temp_reg_t;

    mrr_temp_reg_t s_q, s_d;
    logic chan_ok;

    assign chan_ok = HAS_CH3 || (conv_chan != MRR_CH_THIRD);
    assign conv_go = conv_req && s_q.sup_s2 && !s_q.active && chan_ok;

    always_comb begin
        s_d = s_q;
        s_d.sup_s1 = supply_ok_pin;
        s_d.sup_s2 = s_q.sup_s1;
        s_d.dio_s1 = diode_open_pin;
        s_d.dio_s2 = s_q.dio_s1;
        s_d.commit = 1'b0;
        if (conv_go) begin
            s_d.active = 1'b1;
            s_d.chan = conv_chan;
            s_d.drop = 1'b0;
            s_d.open = 1'b0;
        end else if (s_q.active) begin
            s_d.drop = s_q.drop || !s_q.sup_s2;
            s_d.open = s_q.open || s_q.dio_s2;
            if (conv_done) begin
                s_d.active = 1'b0;
                s_d.commit = 1'b1;
                s_d.word = MRR_RESET_WORD;
                s_d.word[15:MRR_CODE_LSB] = conv_code;
                s_d.word[MRR_SUPPLY_BIT] = s_q.drop || !s_q.sup_s2;
                s_d.word[MRR_OPEN_BIT] = (s_q.chan != MRR_CH_LOCAL)
                    && (s_q.open || s_q.dio_s2);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign commit = s_q.commit;
    assign commit_chan = s_q.chan;
    assign commit_word = s_q.word;
endmodule
`default_nettype wire

// *** mrr_top.sv ***
// result and limit registers of the supply and temperature monitor
// assumes the serial bus front end presents a word-wide register port
`timescale 1ns/1ns
`default_nettype none
module mrr_top #(
    parameter bit HAS_CH3 = 1'b1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    // bus voltage converter
    input wire logic bus_valid,
    input wire logic [12:0] bus_voltage_bits,
    input wire logic range_16v,
    // shunt converter and calibration
    input wire logic shunt_valid,
    input wire logic [15:0] shunt_code,
    input wire logic [15:0] calibration,
    // temperature converter
    input wire logic temp_conv_req,
    input wire logic [1:0] temp_conv_chan,
    output logic temp_conv_go,
    input wire logic temp_conv_done,
    input wire logic [12:0] temp_conv_code,
    input wire logic supply_ok_pin,
    input wire logic diode_open_pin,
    // limit out to the comparators
    output logic [15:0] shunt_upper_limit_bits
);
    import mrr_pkg::*;

    typedef struct packed {
        logic [15:0] bus;
        logic [15:0] power;
        logic [15:0] current;
        logic [3:0][15:0] temp;
        logic [15:0] limit;
        logic [15:0] rdata;
    } mrr_top_reg_t;

    mrr_top_reg_t s_q, s_d;
    logic ar_valid;
    logic [15:0] ar_current;
    logic [15:0] ar_power;
    logic t_commit;
    logic [1:0] t_chan;
    logic [15:0] t_word;

    // --------------------------------------------------------------
    // arithmetic and temperature units
    // --------------------------------------------------------------
    mrr_arith u_arith (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .shunt_valid(shunt_valid),
        .shunt_code(shunt_code),
        .calibration(calibration),
        .bus_code(s_q.bus[15:MRR_CODE_LSB]),
        .result_valid(ar_valid),
        .current_word(ar_current),
        .power_word(ar_power)
    );

    mrr_temp #(
        .HAS_CH3(HAS_CH3)
    ) u_temp (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .conv_req(temp_conv_req),
        .conv_chan(temp_conv_chan),
        .conv_done(temp_conv_done),
        .conv_code(temp_conv_code),
        .conv_go(temp_conv_go),
        .supply_ok_pin(supply_ok_pin),
        .diode_open_pin(diode_open_pin),
        .commit(t_commit),
        .commit_chan(t_chan),
        .commit_word(t_word)
    );

    // --------------------------------------------------------------
    // register update and read mux
    // --------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (bus_valid) begin
            s_d.bus = MRR_RESET_WORD;
            if (range_16v) begin
                s_d.bus[14:MRR_CODE_LSB] = bus_voltage_bits[11:0];
            end else begin
                s_d.bus[15:MRR_CODE_LSB] = bus_voltage_bits;
            end
        end
        if (ar_valid) begin
            s_d.current = ar_current;
            s_d.power = ar_power;
        end
        if (t_commit) begin
            s_d.temp[t_chan] = t_word;
        end
        if (reg_wr && reg_addr == MRR_OFS_SHUNT_UPPER) begin
            s_d.limit = reg_wdata;
        end
        unique case (reg_addr)
            MRR_OFS_BUS: s_d.rdata = s_q.bus;
            MRR_OFS_POWER: s_d.rdata = s_q.power;
            MRR_OFS_CURRENT: s_d.rdata = s_q.current;
            MRR_OFS_LOCAL: s_d.rdata = s_q.temp[0];
            MRR_OFS_REMOTE1: s_d.rdata = s_q.temp[1];
            MRR_OFS_REMOTE2: s_d.rdata = s_q.temp[2];
            MRR_OFS_REMOTE3: s_d.rdata = HAS_CH3 ? s_q.temp[3] : MRR_RESET_WORD;
            MRR_OFS_SHUNT_UPPER: s_d.rdata = s_q.limit;
            default: s_d.rdata = MRR_RESET_WORD;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign shunt_upper_limit_bits = s_q.limit;
endmodule
`default_nettype wire

// *** mrr_top_props.sv ***
// port-level properties of the monitor result registers
// assumes it is bound into mrr_top and sees its ports only
`timescale 1ns/1ns
`default_nettype none
module mrr_top_props (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    // converters
    input wire logic bus_valid,
    input wire logic [12:0] bus_voltage_bits,
    input wire logic range_16v,
    input wire logic temp_conv_req,
    input wire logic temp_conv_go,
    input wire logic supply_ok_pin,
    // limit
    input wire logic [15:0] shunt_upper_limit_bits
);
    // ------------------------------
    // properties
    // ------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    bus_wide_a: assert property (bus_valid && !range_16v ##1 reg_addr == 8'h05
        |=> reg_rdata == {$past(bus_voltage_bits, 2), 3'b000}) else $error("bus word bad");
    bus_narrow_a: assert property (bus_valid && range_16v ##1 reg_addr == 8'h05
        |=> reg_rdata == {1'b0, $past(bus_voltage_bits[11:0], 2), 3'b000}) else $error("bus16 bad");
    limit_load_a: assert property (reg_wr && reg_addr == 8'h0C
        |=> shunt_upper_limit_bits == $past(reg_wdata)) else $error("limit not loaded");
    limit_keep_a: assert property (!(reg_wr && reg_addr == 8'h0C)
        |=> $stable(shunt_upper_limit_bits)) else $error("limit changed");
    bus_low_a: assert property (reg_addr == 8'h05
        |=> reg_rdata[2:0] == 3'b000) else $error("bus low bits set");
    temp_gap_a: assert property (reg_addr inside {[8'h08:8'h0B]}
        |=> !reg_rdata[2]) else $error("temp bit 2 set");
    unmapped_zero_a: assert property (!(reg_addr inside {[8'h05:8'h0C]})
        |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
    go_supply_a: assert property (temp_conv_go
        |-> temp_conv_req && $past(supply_ok_pin, 2)) else $error("go without supply");
    go_single_a: assert property (temp_conv_go |=> !temp_conv_go) else $error("go twice");
endmodule
bind mrr_top mrr_top_props u_props (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .bus_valid(bus_valid),
    .bus_voltage_bits(bus_voltage_bits), .range_16v(range_16v), .temp_conv_req(temp_conv_req),
    .temp_conv_go(temp_conv_go), .supply_ok_pin(supply_ok_pin),
    .shunt_upper_limit_bits(shunt_upper_limit_bits));
`default_nettype wire

// *** mrr_host.sv ***
// host model on the word-wide register port
// assumes the bench calls its tasks; changes signals only after edges
`timescale 1ns/1ns
`default_nettype none
module mrr_host (
    // clock
    input wire logic sys_clk,
    // register port
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata
);
    // ------------------------------
    // bus cycles
    // ------------------------------
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 16'h0000;
    end
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wr <= 1'b1;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        repeat (2) @(posedge sys_clk);
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the monitor result registers
// assumes mrr_host drives the register port
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
    $display("unexpected %0t: %h not %h", $time, a, e); end end
module tb_top;
    import mrr_pkg::*;
    logic sys_clk = 0, rstn = 0, bus_valid = 0, range_16v = 0, shunt_valid = 0, reg_wr;
    logic temp_conv_req = 0, temp_conv_done = 0, supply_ok_pin = 1, diode_open_pin = 0;
    logic temp_conv_go;
    logic [1:0] temp_conv_chan = 0;
    logic [7:0] reg_addr;
    logic [12:0] bus_voltage_bits = 0, temp_conv_code = 0;
    logic [15:0] reg_wdata, reg_rdata, lim, shunt_code = 0, calibration = 0;
    int fails = 0, check_count = 0, cyc = 0;
    mrr_top uut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .bus_valid(bus_valid),
        .bus_voltage_bits(bus_voltage_bits), .range_16v(range_16v), .shunt_valid(shunt_valid),
        .shunt_code(shunt_code), .calibration(calibration), .temp_conv_req(temp_conv_req),
        .temp_conv_chan(temp_conv_chan), .temp_conv_go(temp_conv_go),
        .temp_conv_done(temp_conv_done), .temp_conv_code(temp_conv_code),
        .supply_ok_pin(supply_ok_pin), .diode_open_pin(diode_open_pin),
        .shunt_upper_limit_bits(lim));
    mrr_host h (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    // ------------------------------
    // clock, timeout, close
    // ------------------------------
    initial forever #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        h.rd(a, d);
        `CHK(d, e)
    endtask
    // ------------------------------
    // scenarios
    // ------------------------------
    task automatic bus(input logic r, input logic [12:0] c, input logic [15:0] e);
        @(posedge sys_clk);
        bus_valid <= 1'b1;
        range_16v <= r;
        bus_voltage_bits <= c;
        @(posedge sys_clk);
        bus_valid <= 1'b0;
        rd_chk(MRR_OFS_BUS, e);
    endtask
    task automatic shunt(input logic [15:0] s, cal, ec, ep);
        @(posedge sys_clk);
        shunt_valid <= 1'b1;
        shunt_code <= s;
        calibration <= cal;
        @(posedge sys_clk);
        shunt_valid <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rd_chk(MRR_OFS_CURRENT, ec);
        rd_chk(MRR_OFS_POWER, ep);
    endtask
    task automatic conv(input logic [1:0] ch, input logic [12:0] c, input logic op, dr,
        input logic [15:0] e);
        int n = 0;
        @(posedge sys_clk);
        diode_open_pin <= op;
        temp_conv_req <= 1'b1;
        temp_conv_chan <= ch;
        do @(posedge sys_clk); while (temp_conv_go !== 1'b1 && ++n < 20);
        temp_conv_req <= 1'b0;
        if (dr) supply_ok_pin <= 1'b0;
        repeat (4) @(posedge sys_clk);
        supply_ok_pin <= 1'b1;
        repeat (2) @(posedge sys_clk);
        temp_conv_done <= 1'b1;
        temp_conv_code <= c;
        @(posedge sys_clk);
        temp_conv_done <= 1'b0;
        repeat (2) @(posedge sys_clk);
        diode_open_pin <= 1'b0;
        rd_chk(MRR_OFS_LOCAL + 8'(ch), e);
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        for (int a = 0; a < 14; a++) rd_chk(8'(a), MRR_RESET_WORD);
        `CHK(lim, MRR_RESET_WORD)
        $display("test reset done");
        bus(0, MRR_BUS_FS_32V, 16'hFA00);
        bus(1, MRR_BUS_FS_16V, 16'h7D00);
        bus(1, 13'h1FA0, 16'h7D00);
        bus(0, 13'h1388, 16'h9C40);
        h.wr(MRR_OFS_BUS, 16'hFFFF);
        rd_chk(MRR_OFS_BUS, 16'h9C40);
        $display("test bus done");
        shunt(16'h0064, 16'h1000, 16'h0064, 16'h0064);
        shunt(16'hFF38, 16'h2001, 16'hFE70, 16'h0190);
        h.wr(MRR_OFS_CURRENT, 16'h1234);
        rd_chk(MRR_OFS_CURRENT, 16'hFE70);
        shunt(16'h8000, 16'hFFFF, 16'h8000, 16'h8000);
        $display("test shunt done");
        conv(MRR_CH_LOCAL, 13'h0960, 0, 0, 16'h4B00);
        conv(2'h1, 13'h1E70, 1, 0, 16'hF381);
        conv(2'h2, 13'h0004, 0, 1, 16'h0022);
        supply_ok_pin <= 1'b0;
        repeat (3) @(posedge sys_clk);
        temp_conv_req <= 1'b1;
        repeat (3) @(posedge sys_clk);
        `CHK(temp_conv_go, 1'b0)
        temp_conv_req <= 1'b0;
        supply_ok_pin <= 1'b1;
        conv(MRR_CH_THIRD, 13'h1C90, 0, 0, 16'hE480);
        $display("test temp done");
        h.wr(MRR_OFS_SHUNT_UPPER, MRR_LIMIT_POS_FS);
        rd_chk(MRR_OFS_SHUNT_UPPER, MRR_LIMIT_POS_FS);
        h.wr(MRR_OFS_SHUNT_UPPER, MRR_LIMIT_NEG_FS);
        rd_chk(MRR_OFS_SHUNT_UPPER, MRR_LIMIT_NEG_FS);
        `CHK(lim, MRR_LIMIT_NEG_FS)
        $display("test limit done");
        stop_test();
    end
endmodule
`default_nettype wire
